// ==== common/oci_pkg.sv ====
// Package with register map, field layout and constants of the OTP integrity block
package oci_pkg;
	// Register addresses of lock/CRC bytes
	localparam logic [7:0] ADDR_MIRROR_LOCK_CRC = 8'h5F;
	localparam logic [7:0] ADDR_BLOCK_A_LOCK_CRC = 8'hAF;
	localparam logic [7:0] ADDR_BLOCK_B_LOCK_CRC = 8'hBF;
	localparam logic [7:0] ADDR_BLOCK_C_LOCK_CRC = 8'hCF;
	localparam logic [7:0] ADDR_BLOCK_D_LOCK_CRC = 8'hDF;
	localparam logic [7:0] ADDR_BLOCK_E_LOCK_CRC = 8'hEF;
	localparam logic [7:0] ADDR_BLOCK_F_LOCK_CRC = 8'hFF;
	// Own status register holding error flags
	localparam logic [7:0] ADDR_DEVICE_STATUS_ONE = 8'h10;
	// Mirror region, user writable array and device lock register
	localparam logic [7:0] ADDR_MIRROR_BASE = 8'h50;
	localparam logic [7:0] ADDR_RW_BASE = 8'h40;
	localparam logic [7:0] ADDR_DEVICE_LOCK_WR = 8'h4F;
	// Block geometry
	localparam int BLOCK_BYTES = 16;
	localparam int NUM_BLOCKS = 7;
	localparam logic [3:0] LAST_BYTE_IDX = 4'hF;
	// Lock/CRC byte field positions
	localparam int LOCK_BIT = 7;
	localparam int ID_HI = 6;
	localparam int ID_LO = 4;
	localparam int CRC_HI = 3;
	localparam int CRC_LO = 0;
	// CRC polynomial x^4+x^3+1 (low terms) and seed
	localparam logic [3:0] CRC_POLY = 4'h9;
	localparam logic [3:0] CRC_SEED = 4'h0;
	// Block identifiers, index 0 = mirror, 1..6 = blocks A..F
	localparam logic [2:0] BLOCK_ID [NUM_BLOCKS] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
	// Upper address nibble of each block
	localparam logic [3:0] BLOCK_NIB [NUM_BLOCKS] = '{4'h5, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
	// Status register bit positions
	localparam int STAT_BUF_ERR = 0;
	localparam int STAT_OTP_CRC_ERR = 1;
	localparam int STAT_RUN_CRC_ERR = 2;
	localparam int STAT_INIT_DONE = 3;
	// Reset values
	localparam logic [7:0] LOCK_CRC_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	localparam logic [3:0] NIB_ONE = 4'h1;

	// Register command from the host side
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] data;
	} oci_cmd_t;

	// Register answer to the host side
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} oci_rsp_t;

	// Sequencer states, one bit apart from idle to burn and from idle to check
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BURN = 2'b10,
		ST_CHECK = 2'b01
	} oci_state_t;
endpackage

// ==== rtl/oci_otp_crc_integrity.sv ====
// OTP block lock/CRC programming, CRC checking and register command answers
`timescale 1ns/1ps
// Overview of operation
// - Burn auto-programs lock, identifier and CRC
// - Lock bit7, identifier 6:4, CRC 3:0
// - Identifiers 000 mirror, 001..110 blocks A-F
// - Unburned lock 0, identifier and CRC zero
// - Reserved reads answer validly, any value
// - Reserved writes execute, answer validly
// - Unmapped reads answer valid zero data
// - Unmapped writes change nothing, answer zero
// - Read-only writes ignored, return contents
// - Each 16-byte OTP block has CRC check
// - Polynomial x^4+x^3+1, seed zero
// - MSB first, ascending byte addresses
// - Mirror region CRC kept in its lock byte
// - Mirror writable only before init done
// - After init, continuous CRC except lock register
// - Held in reset until supplies good
// - Buffer undervoltage sets status flag; the code sets it only while protocolSlot is high
// - Capacitor test synchronised to protocol traffic
// - User data included in OTP error detection
module oci_otp_crc_integrity (
	input wire logic clk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic suppliesGood,
	input wire logic bufferBelowThreshold,
	input wire logic protocolSlot,
	input wire logic initDoneFlag,
	input wire logic burnStart,
	input wire logic [2:0] burnBlock,
	input wire oci_pkg::oci_cmd_t cmdIn,
	output oci_pkg::oci_rsp_t rspOut,
	output logic capTestStrobe,
	output logic busy
);
	// Internal reset combines pin and supply monitor
	logic rstActiveN;
	assign rstActiveN = rstn & suppliesGood;

	// Mirror region bytes; entry 15 stands for the lock byte and stays zero
	// Factory and user OTP blocks are loaded outside this block and read as cleared,
	// so only the mirror needs storage here
	logic [7:0] mirrorMem [oci_pkg::BLOCK_BYTES];
	// Byte under the sequencer and byte addressed by the command
	logic [7:0] seqByte;
	logic [7:0] cmdByte;
	// Writable register array covered by the running CRC
	logic [7:0] rwMem [oci_pkg::BLOCK_BYTES];
	// Lock/CRC bytes per block
	logic [7:0] lockCrc_reg [oci_pkg::NUM_BLOCKS];
	// Status flags
	logic bufErr_reg;
	logic otpCrcErr_reg;
	logic runCrcErr_reg;
	// Sequencer
	oci_pkg::oci_state_t state_reg;
	logic [2:0] blk_reg;
	logic [3:0] byteIdx_reg;
	logic [3:0] crc_reg;
	// Burn request that may start now; a burn in progress is never cut
	logic burnReq;
	// Running CRC over writable array then mirror
	logic [4:0] runIdx_reg;
	logic [3:0] runCrc_reg;
	logic [3:0] runRef_reg;
	logic runRefValid_reg;
	// Running CRC after the current byte, skip applied
	logic [3:0] runNext;

	// One byte step of the CRC, MSB first
	// Shift-register form: the bit leaving bit 3, xored with the data bit,
	// folds the low taps of x^4+x^3+1 back in
	function automatic logic [3:0] crcByte(input logic [3:0] c, input logic [7:0] d);
		logic [3:0] r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[3] ^ d[i];
			r = {r[2:0], 1'b0} ^ (fb ? oci_pkg::CRC_POLY : oci_pkg::NIB_ZERO);
		end
		return r;
	endfunction

	// Command decode
	// Lock byte is the last byte of each block; data bytes are the other 15
	logic [3:0] hiNib;
	logic [3:0] loNib;
	logic isLockAddr;
	logic isDataAddr;
	logic isRwAddr;
	logic isStatus;
	logic [2:0] blkSel;
	always_comb begin
		hiNib = cmdIn.addr[7:4];
		loNib = cmdIn.addr[3:0];
		blkSel = 3'h0;
		isLockAddr = 1'b0;
		isDataAddr = 1'b0;
		for (int b = 0; b < oci_pkg::NUM_BLOCKS; b++) begin
			if (hiNib == oci_pkg::BLOCK_NIB[b]) begin
				blkSel = 3'(b);
				isLockAddr = (loNib == oci_pkg::LAST_BYTE_IDX);
				isDataAddr = (loNib != oci_pkg::LAST_BYTE_IDX);
			end
		end
		isRwAddr = (hiNib == oci_pkg::ADDR_RW_BASE[7:4]);
		isStatus = (cmdIn.addr == oci_pkg::ADDR_DEVICE_STATUS_ONE);
	end

	// Writes: mirror only before init done, OTP blocks only through burn
	logic mirrorWr;
	logic rwWr;
	assign mirrorWr = cmdIn.valid & cmdIn.write & isDataAddr & (blkSel == 3'h0)
		& ~initDoneFlag;
	assign rwWr = cmdIn.valid & cmdIn.write & isRwAddr;

	// Mirror data storage; reset stands in for the OTP reload at power-up
	always_ff @(posedge clk) begin
		if (!rstActiveN) begin
			// Cleared like unprogrammed OTP
			for (int i = 0; i < oci_pkg::BLOCK_BYTES; i++) begin
				mirrorMem[i] <= oci_pkg::DATA_RESET;
			end
		end else if (clkEn && mirrorWr) begin
			// Lock byte address never reaches here, so entry 15 stays clear
			mirrorMem[loNib] <= cmdIn.data;
		end
	end

	// Factory blocks read as cleared; only block 0 has storage
	// A check pass over a factory block therefore sees fifteen zero bytes
	assign seqByte = (blk_reg == 3'h0) ? mirrorMem[byteIdx_reg] : oci_pkg::DATA_RESET;
	assign cmdByte = (blkSel == 3'h0) ? mirrorMem[loNib] : oci_pkg::DATA_RESET;

	// Writable register array, device lock included but not CRC'd
	always_ff @(posedge clk) begin
		if (!rstActiveN) begin
			for (int i = 0; i < oci_pkg::BLOCK_BYTES; i++) begin
				rwMem[i] <= oci_pkg::DATA_RESET;
			end
		end else if (clkEn && rwWr) begin
			rwMem[loNib] <= cmdIn.data;
		end
	end

	// Answer: always valid next cycle
	always_ff @(posedge clk) begin
		if (!rstActiveN) begin
			rspOut <= '0;
		end else if (clkEn) begin
			// Every command is answered, whatever its address
			rspOut.valid <= cmdIn.valid;
			if (isLockAddr) begin
				// Lock bytes are read-only: a write gets the contents back
				rspOut.data <= lockCrc_reg[blkSel];
			end else if (isDataAddr) begin
				// Mirror echoes an accepted write; other data reads as stored
				rspOut.data <= mirrorWr ? cmdIn.data : cmdByte;
			end else if (isRwAddr) begin
				// Writable array echoes the written byte
				rspOut.data <= cmdIn.write ? cmdIn.data : rwMem[loNib];
			end else if (isStatus) begin
				// Status is read-only; upper bits read zero
				rspOut.data <= {4'h0, initDoneFlag, runCrcErr_reg, otpCrcErr_reg, bufErr_reg};
			end else begin
				// Unmapped: nothing stored, data zero
				rspOut.data <= oci_pkg::READ_ZERO;
			end
		end
	end

	// A burn request is taken in idle or in a check pass; a check pass is
	// cheap to repeat, so it gives way rather than let a one-cycle request drop
	assign burnReq = burnStart && (burnBlock < 3'(oci_pkg::NUM_BLOCKS))
		&& (state_reg != oci_pkg::ST_BURN);

	// Burn and check sequencer
	always_ff @(posedge clk) begin
		if (!rstActiveN) begin
			state_reg <= oci_pkg::ST_IDLE;
			blk_reg <= 3'h0;
			byteIdx_reg <= oci_pkg::NIB_ZERO;
			crc_reg <= oci_pkg::CRC_SEED;
		end else if (clkEn) begin
			if (burnReq) begin
				// Fresh pass over the requested block
				blk_reg <= burnBlock;
				byteIdx_reg <= oci_pkg::NIB_ZERO;
				crc_reg <= oci_pkg::CRC_SEED;
				state_reg <= oci_pkg::ST_BURN;
			end else begin
				case (state_reg)
					oci_pkg::ST_IDLE: begin
						// Seed and rewind, then check the next block in turn
						crc_reg <= oci_pkg::CRC_SEED;
						byteIdx_reg <= oci_pkg::NIB_ZERO;
						blk_reg <= (blk_reg == 3'(oci_pkg::NUM_BLOCKS - 1)) ? 3'h0
							: blk_reg + 3'h1;
						state_reg <= oci_pkg::ST_CHECK;
					end
					oci_pkg::ST_BURN, oci_pkg::ST_CHECK: begin
						// One byte per cycle, lowest address first
						crc_reg <= crcByte(crc_reg, seqByte);
						byteIdx_reg <= byteIdx_reg + oci_pkg::NIB_ONE;
						// Byte 15 is the lock byte itself and is left out
						if (byteIdx_reg == oci_pkg::LAST_BYTE_IDX - oci_pkg::NIB_ONE) begin
							state_reg <= oci_pkg::ST_IDLE;
						end
					end
					default: state_reg <= oci_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// Final CRC of current pass
	logic passEnd;
	logic [3:0] passCrc;
	assign passEnd = (state_reg != oci_pkg::ST_IDLE)
		&& (byteIdx_reg == oci_pkg::LAST_BYTE_IDX - oci_pkg::NIB_ONE);
	assign passCrc = crcByte(crc_reg, seqByte);

	// Lock/CRC bytes: written once at end of a burn
	always_ff @(posedge clk) begin
		if (!rstActiveN) begin
			for (int b = 0; b < oci_pkg::NUM_BLOCKS; b++) begin
				lockCrc_reg[b] <= oci_pkg::LOCK_CRC_RESET;
			end
		end else if (clkEn && passEnd && state_reg == oci_pkg::ST_BURN
			&& !lockCrc_reg[blk_reg][oci_pkg::LOCK_BIT]) begin
			lockCrc_reg[blk_reg][oci_pkg::LOCK_BIT] <= 1'b1;
			lockCrc_reg[blk_reg][oci_pkg::ID_HI:oci_pkg::ID_LO] <= oci_pkg::BLOCK_ID[blk_reg];
			lockCrc_reg[blk_reg][oci_pkg::CRC_HI:oci_pkg::CRC_LO] <= passCrc;
		end
	end

	// Continuous CRC over writable array then mirror after init done
	// Writable array comes first so bytes run in ascending address; the device
	// lock register and the read-only mirror lock byte are skipped
	logic [7:0] runByte;
	logic runSkip;
	assign runSkip = runIdx_reg[4] ? (runIdx_reg[3:0] == oci_pkg::LAST_BYTE_IDX)
		: (runIdx_reg[3:0] == oci_pkg::ADDR_DEVICE_LOCK_WR[3:0]);
	assign runByte = runIdx_reg[4] ? mirrorMem[runIdx_reg[3:0]] : rwMem[runIdx_reg[3:0]];
	assign runNext = runSkip ? runCrc_reg : crcByte(runCrc_reg, runByte);
	always_ff @(posedge clk) begin
		if (!rstActiveN) begin
			runIdx_reg <= 5'h00;
			runCrc_reg <= oci_pkg::CRC_SEED;
			runRef_reg <= oci_pkg::CRC_SEED;
			runRefValid_reg <= 1'b0;
		end else if (clkEn) begin
			if (!initDoneFlag) begin
				// Idle until init is done; a later start takes a fresh reference
				runIdx_reg <= 5'h00;
				runCrc_reg <= oci_pkg::CRC_SEED;
				runRef_reg <= oci_pkg::CRC_SEED;
				runRefValid_reg <= 1'b0;
			end else begin
				runIdx_reg <= runIdx_reg + 5'h01;
				if (runIdx_reg == 5'h1F) begin
					// End of array: reseed and keep this pass as reference
					runCrc_reg <= oci_pkg::CRC_SEED;
					runRef_reg <= runNext;
					runRefValid_reg <= 1'b1;
				end else begin
					runCrc_reg <= runNext;
				end
			end
		end
	end

	// Error flags: sticky, cleared only by reset
	always_ff @(posedge clk) begin
		if (!rstActiveN) begin
			bufErr_reg <= 1'b0;
			otpCrcErr_reg <= 1'b0;
			runCrcErr_reg <= 1'b0;
		end else if (clkEn) begin
			if (protocolSlot && bufferBelowThreshold) begin
				bufErr_reg <= 1'b1;
			end
			if (passEnd && state_reg == oci_pkg::ST_CHECK && lockCrc_reg[blk_reg][oci_pkg::LOCK_BIT]
				&& passCrc != lockCrc_reg[blk_reg][oci_pkg::CRC_HI:oci_pkg::CRC_LO]) begin
				otpCrcErr_reg <= 1'b1;
			end
			// Reference is the previous full pass; drift between passes is corruption
			// Compared at the last byte, so the skipped lock byte cannot hide it
			if (initDoneFlag && runRefValid_reg && runIdx_reg == 5'h1F && runNext != runRef_reg) begin
				runCrcErr_reg <= 1'b1;
			end
		end
	end

	// Capacitor test strobe and busy flag, registered
	always_ff @(posedge clk) begin
		if (!rstActiveN) begin
			capTestStrobe <= 1'b0;
			busy <= 1'b0;
		end else if (clkEn) begin
			capTestStrobe <= protocolSlot;
			busy <= (state_reg == oci_pkg::ST_BURN);
		end
	end
endmodule

// ==== tb/oci_otp_crc_integrity_assertions.sv ====
// Assertion checker for the OTP lock/CRC integrity block
`timescale 1ns/1ps
module oci_otp_crc_integrity_checker (
	input wire logic clk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic suppliesGood,
	input wire logic bufferBelowThreshold,
	input wire logic protocolSlot,
	input wire logic initDoneFlag,
	input wire logic burnStart,
	input wire logic [2:0] burnBlock,
	input wire oci_pkg::oci_cmd_t cmdIn,
	input wire oci_pkg::oci_rsp_t rspOut,
	input wire logic capTestStrobe,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// A command that the block must take on this edge
	wire logic take = clkEn && suppliesGood && cmdIn.valid;
	// Addresses 0x00-0x0F hold nothing in the map
	wire logic unmapped = cmdIn.addr[7:4] == 4'h0;
	// Write then read of the mirror lock byte, one idle cycle apart
	sequence s_lock_wr;
		take && cmdIn.write && cmdIn.addr == oci_pkg::ADDR_MIRROR_LOCK_CRC && !busy && !burnStart;
	endsequence
	sequence s_lock_rd;
		take && !cmdIn.write && cmdIn.addr == oci_pkg::ADDR_MIRROR_LOCK_CRC;
	endsequence
	property p_answer; take |=> rspOut.valid; endproperty
	a_answer: assert property (p_answer) else $error("command left unanswered");
	property p_no_stray; rspOut.valid |-> $past(take); endproperty
	a_no_stray: assert property (p_no_stray) else $error("answer without command");
	property p_unmapped; take && unmapped |=> rspOut.data == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped data not zero");
	property p_echo;
		take && cmdIn.write && cmdIn.addr[7:4] == 4'h4 && cmdIn.addr != 8'h4F
			|=> rspOut.data == $past(cmdIn.data);
	endproperty
	a_echo: assert property (p_echo) else $error("write not echoed");
	property p_ro_write;
		s_lock_wr ##2 s_lock_rd |=> rspOut.data == $past(rspOut.data, 2);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only byte changed");
	property p_burn_start;
		burnStart && burnBlock != 3'h7 && clkEn && suppliesGood && !busy |-> ##[1:2] busy;
	endproperty
	a_burn_start: assert property (p_burn_start) else $error("burn did not start");
	property p_burn_end; $rose(busy) |-> ##[1:40] !busy; endproperty
	a_burn_end: assert property (p_burn_end) else $error("burn pass too long");
	property p_cap_test;
		$past(rstn) && $past(clkEn) && $past(suppliesGood)
			|-> capTestStrobe == $past(protocolSlot);
	endproperty
	a_cap_test: assert property (p_cap_test) else $error("capacitor test off slot");
	property p_supply; !suppliesGood |=> !busy && !rspOut.valid && !capTestStrobe; endproperty
	a_supply: assert property (p_supply) else $error("supply loss did not reset");
endmodule
bind oci_otp_crc_integrity oci_otp_crc_integrity_checker u_checker (.clk(clk), .rstn(rstn),
	.clkEn(clkEn), .suppliesGood(suppliesGood), .bufferBelowThreshold(bufferBelowThreshold),
	.protocolSlot(protocolSlot), .initDoneFlag(initDoneFlag), .burnStart(burnStart),
	.burnBlock(burnBlock), .cmdIn(cmdIn), .rspOut(rspOut), .capTestStrobe(capTestStrobe),
	.busy(busy));

// ==== tb/oci_host_model.sv ====
// Behavioural host issuing register commands to the integrity block
`timescale 1ns/1ps
module oci_host_model (
	input wire logic clk,
	output oci_pkg::oci_cmd_t cmd,
	input wire oci_pkg::oci_rsp_t rsp
);
	initial cmd = '0;
	// One command, entered at a falling edge; callers keep reserved bits zero
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data,
		output logic [7:0] q);
		cmd = {1'b1, wr, addr, data};
		@(negedge clk);
		// The answer stands only in the cycle after the sampling edge
		// A missing answer turns the data unknown, so the compare fails
		q = (rsp.valid === 1'b1) ? rsp.data : 8'hXX;
		// Released fields are scrambled so stale values never pass
		cmd = {1'b0, ~wr, ~addr, ~data};
		@(negedge clk);
	endtask
endmodule

// ==== tb/oci_otp_crc_integrity_tb_top.sv ====
// Self-checking testbench for the OTP lock/CRC integrity block
`timescale 1ns/1ps
module oci_otp_crc_integrity_tb_top;
	typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} oci_row_t;
	logic clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, suppliesGood = 1'b1, bufLow = 1'b0;
	logic protocolSlot = 1'b0, initDoneFlag = 1'b0, burnStart = 1'b0;
	logic [2:0] burnBlock = 3'h0;
	logic capTestStrobe, busy;
	oci_pkg::oci_cmd_t cmdIn;
	oci_pkg::oci_rsp_t rspOut;
	int n_mismatch = 0, check_count = 0;
	// Ordinary register commands and the answers they must give
	oci_row_t rows [10] = '{'{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b1, 8'h03, 8'hAA, 8'h00},
		'{1'b0, 8'h03, 8'h00, 8'h00}, '{1'b1, 8'h40, 8'h5A, 8'h5A}, '{1'b0, 8'h40, 8'h00, 8'h5A},
		'{1'b0, 8'h5F, 8'h00, 8'h00}, '{1'b1, 8'h5F, 8'h8F, 8'h00}, '{1'b0, 8'h5F, 8'h00, 8'h00},
		'{1'b0, 8'hEF, 8'h00, 8'h00}, '{1'b0, 8'hFF, 8'h00, 8'h00}};
	always #5 clk = ~clk;
	oci_otp_crc_integrity dut (.clk(clk), .rstn(rstn), .clkEn(clkEn), .suppliesGood(suppliesGood),
		.bufferBelowThreshold(bufLow), .protocolSlot(protocolSlot), .initDoneFlag(initDoneFlag),
		.burnStart(burnStart), .burnBlock(burnBlock), .cmdIn(cmdIn), .rspOut(rspOut),
		.capTestStrobe(capTestStrobe), .busy(busy));
	oci_host_model host (.clk(clk), .cmd(cmdIn), .rsp(rspOut));
	// Compare and count
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Watchdog well beyond the roughly 1100 cycles the run needs
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
	initial begin
		logic [7:0] q, d;
		logic [3:0] c;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		foreach (rows[i]) begin
			host.xfer(rows[i].wr, rows[i].addr, rows[i].data, q);
			check("table answer", rows[i].exp, q);
		end
		// Fill the mirror, folding each byte MSB first into a zero-seeded CRC
		c = 4'h0;
		for (int i = 0; i < 15; i++) begin
			d = 8'(i * 37 + 5);
			protocolSlot = i[0];
			host.xfer(1'b1, 8'h50 + 8'(i), d, q);
			for (int j = 7; j >= 0; j--) c = {c[2:0], 1'b0} ^ ((c[3] ^ d[j]) ? 4'h9 : 4'h0);
		end
		// Burn each block; factory data reads zero, so only the mirror CRC varies
		for (int b = 0; b < 7; b++) begin
			burnBlock = 3'(b);
			burnStart = 1'b1;
			@(negedge clk);
			burnStart = 1'b0;
			// Busy lags the request by a cycle: see it rise, then fall
			for (int k = 0; k < 60 && busy !== 1'b1; k++) @(negedge clk);
			for (int k = 0; k < 60 && busy !== 1'b0; k++) @(negedge clk);
			repeat (2) @(negedge clk);
			d = {b == 0 ? 4'h5 : 4'(9 + b), 4'hF};
			host.xfer(1'b0, d, 8'h00, q);
			check("lock byte", {1'b1, 3'(b), b == 0 ? c : 4'h0}, q);
		end
		// After init the mirror is frozen and the running CRC watches the array
		initDoneFlag = 1'b1;
		host.xfer(1'b1, 8'h50, 8'hEE, q);
		host.xfer(1'b0, 8'h50, 8'h00, q);
		check("mirror frozen", 8'h05, q);
		repeat (300) @(negedge clk);
		host.xfer(1'b1, 8'h4F, 8'h12, q);
		repeat (300) @(negedge clk);
		host.xfer(1'b0, 8'h10, 8'h00, q);
		check("status clean", 8'h08, q & 8'h0F);
		protocolSlot = 1'b1;
		bufLow = 1'b1;
		repeat (2) @(negedge clk);
		check("capacitor strobe", 8'h01, {7'h00, capTestStrobe});
		protocolSlot = 1'b0;
		bufLow = 1'b0;
		host.xfer(1'b1, 8'h41, 8'h34, q);
		repeat (300) @(negedge clk);
		host.xfer(1'b0, 8'h10, 8'h00, q);
		check("status flags", 8'h0D, q & 8'h0F);
		// Frozen clock, then a supply dip clears the sticky flags
		clkEn = 1'b0;
		repeat (3) @(negedge clk);
		clkEn = 1'b1;
		suppliesGood = 1'b0;
		@(negedge clk);
		suppliesGood = 1'b1;
		host.xfer(1'b0, 8'h10, 8'h00, q);
		check("status after dip", 8'h08, q & 8'h0F);
		conclude();
	end
endmodule
